/* core/rlh_link_io.sv */
// linkage-mode discrete i/o command interpreter with APB status access
// assumes one 10 MHz clock, synchronous reset, APB master on clk
`timescale 1ns/10ps
`include "rlh_map.svh"

// Overview of operation
// - start edge in linkage mode begins running the default program
// - stop edge in linkage mode halts the program
// - pause edge toggles between paused and running
// - homing moves only while go-home held; stops at home
// - remote power-on level powers system in either mode
// - remote shutdown level powers system off in either mode
// - message-clear edge clears pending warnings
// - drag teaching enabled only while teach input held
// - running output active exactly while program runs
// - stopped output active from power-up before any start
// - software-alive output active while control software runs
// - at-home output set on arrival at initial position
// - start drops stopped and at-home, raises running
// - pause swaps running for paused; resume swaps back
// - collision pauses a running program and ends a homing move; warning must clear before pause toggle resumes
// - stop drops running and raises stopped
// - manual mode ignores linkage command inputs
// - mode selector latched only at power-on
module rlh_link_io #(
   parameter logic [31:0] GUARD_CYCLES = `RLH_GUARD_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        start_cmd_in,
   input  wire logic        stop_cmd_in,
   input  wire logic        pause_toggle_in,
   input  wire logic        go_home_in,
   input  wire logic        remote_power_on_in,
   input  wire logic        remote_shutdown_in,
   input  wire logic        msg_clear_in,
   input  wire logic        drag_teach_enable_in,
   input  wire logic        mode_link_sel_in,
   output logic             running_out,
   output logic             stopped_out,
   output logic             paused_out,
   output logic             at_home_out,
   output logic             sw_alive_out,
   output logic             power_en_out,
   output logic             drag_teach_out,
   output logic             home_drive_out
);
   import rlh_pkg::*;

   rlh_pins_type            pins;
   rlh_pins_type            lvl;
   rlh_pins_type            rise;
   logic [8:0]              pin_v;
   logic [8:0]              s1_q;
   logic [8:0]              s2_q;
   logic [8:0]              s3_q;
   rlh_state_type           state_q;
   rlh_state_type           state_d;
   rlh_status_type          status_q;
   logic                    power_q;
   logic                    linkage_q;
   logic                    sw_alive_q;
   logic                    warn_q;
   logic                    at_home_q;
   logic                    teach_q;
   logic                    home_drv_q;
   logic                    cmd_en_q;
   logic                    guard_done_q;
   logic [`RLH_GUARD_W-1:0] guard_cnt_q;
   logic [`RLH_EV_W-1:0]    ev_q;
   logic                    link_ok;
   logic                    acc;
   logic                    done;
   logic                    addr_ok;
   logic [`RLH_ST_W-1:0]    stat_v;
   logic [31:0]             rd_d;
   logic                    pready_q;
   logic                    pslverr_q;
   logic [31:0]             prdata_q;

   // pin grouping
   assign pins = '{mode_link: mode_link_sel_in, teach: drag_teach_enable_in,
                   msg_clr: msg_clear_in, shutdown: remote_shutdown_in,
                   pwr_on: remote_power_on_in, home: go_home_in,
                   pause: pause_toggle_in, stop: stop_cmd_in,
                   start: start_cmd_in};
   assign pin_v = pins;

   // two-flop synchroniser and edge stage per pin
   genvar gi;
   for (gi = 0; gi < 9; gi++) begin : g_sync
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            s1_q[gi] <= 1'h0;
            s2_q[gi] <= 1'h0;
            s3_q[gi] <= 1'h0;
         end else begin
            s1_q[gi] <= pin_v[gi];
            s2_q[gi] <= s1_q[gi];
            s3_q[gi] <= s2_q[gi];
         end
      end
   end

   // levels come from the second stage, edges from the second and third, never the first
   assign lvl  = rlh_pins_type'(s2_q);
   assign rise = rlh_pins_type'(s2_q & ~s3_q);

   // linkage commands need power, linkage mode, live software, enable
   assign link_ok = power_q & linkage_q & sw_alive_q & cmd_en_q;

   // apb access phase and completion edge
   assign acc  = psel & penable;
   assign done = acc & pready_q;
   assign addr_ok = (paddr == `RLH_OFF_STATUS) | (paddr == `RLH_OFF_EVENT) |
                    (paddr == `RLH_OFF_CTRL);

   // one wait state keeps prdata and pslverr registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_q  <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~addr_ok;
         prdata_q  <= (acc & ~pready_q & ~pwrite) ? rd_d : 32'h0;
      end
   end

   // status word as seen by software
   always_comb begin
      stat_v = '0;
      stat_v[`RLH_ST_RUNNING]  = status_q.running;
      stat_v[`RLH_ST_STOPPED]  = status_q.stopped;
      stat_v[`RLH_ST_PAUSED]   = status_q.paused;
      stat_v[`RLH_ST_AT_HOME]  = status_q.at_home;
      stat_v[`RLH_ST_SW_ALIVE] = status_q.sw_alive;
      stat_v[`RLH_ST_POWERED]  = power_q;
      stat_v[`RLH_ST_LINKAGE]  = linkage_q;
      stat_v[`RLH_ST_WARN]     = warn_q;
      stat_v[`RLH_ST_TEACH]    = teach_q;
      stat_v[`RLH_ST_GUARD]    = guard_done_q;
      stat_v[`RLH_ST_HOMING]   = home_drv_q;
   end

   // read mux; event register reads as zero
   always_comb begin
      rd_d = 32'h0;
      case (paddr)
         `RLH_OFF_STATUS: rd_d = {21'h0, stat_v};
         `RLH_OFF_CTRL:   rd_d = {31'h0, cmd_en_q};
         default:         rd_d = 32'h0;
      endcase
   end

   // control register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_en_q <= `RLH_CTRL_RESET;
      end else if (done & pwrite & (paddr == `RLH_OFF_CTRL)) begin
         cmd_en_q <= pwdata[`RLH_CTRL_CMD_EN];
      end
   end

   // event pulses from software, one cycle wide
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ev_q <= '0;
      end else if (done & pwrite & (paddr == `RLH_OFF_EVENT)) begin
         ev_q <= pwdata[`RLH_EV_W-1:0];
      end else begin
         ev_q <= '0;
      end
   end

   // power: shutdown wins over power-on for safety
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         power_q <= 1'h0;
      end else if (lvl.shutdown) begin
         power_q <= 1'h0;
      end else if (lvl.pwr_on) begin
         power_q <= 1'h1;
      end
   end

   // mode caught only on the off-to-on step
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         linkage_q <= 1'h0;
      end else if (~power_q & lvl.pwr_on & ~lvl.shutdown) begin
         linkage_q <= lvl.mode_link;
      end
   end

   // software alive; ready beats exit in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst | ~power_q) begin
         sw_alive_q <= 1'h0;
      end else if (ev_q[`RLH_EV_SW_READY]) begin
         sw_alive_q <= 1'h1;
      end else if (ev_q[`RLH_EV_SW_EXIT]) begin
         sw_alive_q <= 1'h0;
      end
   end

   // settle timer, informative only; the controller must wait
   always_ff @(posedge clk) begin
      if (sys_rst | ~sw_alive_q) begin
         guard_cnt_q  <= '0;
         guard_done_q <= 1'h0;
      end else if (~guard_done_q) begin
         guard_cnt_q  <= guard_cnt_q + 1'b1;
         guard_done_q <= (guard_cnt_q == GUARD_CYCLES[`RLH_GUARD_W-1:0] - 1'b1);
      end
   end

   // warnings; a new warning beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         warn_q <= 1'h0;
      end else if (ev_q[`RLH_EV_COLLIDE] | ev_q[`RLH_EV_WARN]) begin
         warn_q <= 1'h1;
      end else if (rise.msg_clr) begin
         warn_q <= 1'h0;
      end
   end

   // drag teaching follows the held input
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         teach_q <= 1'h0;
      end else begin
         teach_q <= power_q & lvl.teach;
      end
   end

   // program sequencer next state
   always_comb begin
      state_d = state_q;
      if (~power_q) begin
         state_d = st_stopped;
      end else begin
         case (state_q)
            st_stopped: begin
               if (link_ok & rise.start) begin
                  state_d = st_running;
               end else if (link_ok & lvl.home & ~at_home_q) begin
                  state_d = st_homing;
               end
            end
            st_running: begin
               if (link_ok & rise.stop) begin
                  state_d = st_stopped;
               end else if (ev_q[`RLH_EV_COLLIDE]) begin
                  state_d = st_paused;
               end else if (link_ok & rise.pause) begin
                  state_d = st_paused;
               end else if (ev_q[`RLH_EV_PRG_DONE]) begin
                  state_d = st_stopped;
               end
            end
            st_paused: begin
               if (link_ok & rise.stop) begin
                  state_d = st_stopped;
               end else if (link_ok & rise.pause & ~warn_q) begin
                  state_d = st_running;
               end
            end
            st_homing: begin
               // release, collision or lost link ends the move at once
               if (ev_q[`RLH_EV_COLLIDE] | ~link_ok | ~lvl.home) begin
                  state_d = st_stopped;
               end else if (ev_q[`RLH_EV_HOME]) begin
                  state_d = st_stopped;
               end
            end
            default: state_d = st_stopped;
         endcase
      end
   end

   // sequencer state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= st_stopped;
      end else begin
         state_q <= state_d;
      end
   end

   // home flag: set on arrival, dropped when a program starts
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         at_home_q <= 1'h0;
      end else if (state_q == st_homing & state_d == st_stopped & ev_q[`RLH_EV_HOME]) begin
         at_home_q <= 1'h1;
      end else if (state_q == st_stopped & state_d == st_running) begin
         at_home_q <= 1'h0;
      end
   end

   // registered outputs, one cycle behind the state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_q   <= `RLH_STATUS_RESET;
         home_drv_q <= 1'h0;
      end else begin
         status_q.running  <= state_q == st_running;
         status_q.stopped  <= state_q == st_stopped | state_q == st_homing;
         status_q.paused   <= state_q == st_paused;
         status_q.at_home  <= at_home_q;
         status_q.sw_alive <= sw_alive_q;
         home_drv_q        <= state_q == st_homing;
      end
   end

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign running_out    = status_q.running;
   assign stopped_out    = status_q.stopped;
   assign paused_out     = status_q.paused;
   assign at_home_out    = status_q.at_home;
   assign sw_alive_out   = status_q.sw_alive;
   assign power_en_out   = power_q;
   assign drag_teach_out = teach_q;
   assign home_drive_out = home_drv_q;

   // checks on the sequencer and its outputs
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_run_out;
      running_out & ~stopped_out & ~paused_out & ~at_home_out;
   endsequence

   sequence s_pause_out;
      paused_out & ~running_out;
   endsequence

   sequence s_stop_out;
      stopped_out & ~running_out & ~paused_out;
   endsequence

   a_start_runs: assert property (state_q == st_stopped & power_q & link_ok & rise.start
      |=> state_q == st_running ##1 s_run_out) else $error("start did not run");

   a_stop_halts: assert property ((state_q == st_running | state_q == st_paused) & power_q
      & link_ok & rise.stop |=> state_q == st_stopped ##1 s_stop_out)
      else $error("stop did not halt");

   a_pause_enter: assert property (state_q == st_running & power_q & link_ok & rise.pause
      & ~rise.stop |=> ##1 s_pause_out) else $error("pause not entered");

   a_pause_resume: assert property (state_q == st_paused & power_q & link_ok & rise.pause
      & ~rise.stop & ~warn_q |=> ##1 s_run_out) else $error("resume failed");

   a_collide_hold: assert property (state_q == st_running & power_q & ~(link_ok & rise.stop)
      & ev_q[`RLH_EV_COLLIDE] |=> warn_q & state_q == st_paused ##1 s_pause_out)
      else $error("collision did not pause");

   a_warn_blocks: assert property (state_q == st_paused & power_q & warn_q & ~rise.stop
      |=> state_q == st_paused) else $error("resumed with warning");

   a_home_release: assert property (state_q == st_homing & ~lvl.home
      |=> state_q == st_stopped ##1 ~home_drive_out) else $error("homing not held");

   a_home_arrive: assert property (state_q == st_homing & power_q & lvl.home & link_ok
      & ev_q[`RLH_EV_HOME] & ~ev_q[`RLH_EV_COLLIDE] |=> ##1 at_home_out & stopped_out)
      else $error("home not flagged");

   a_msg_clear: assert property (rise.msg_clr & ~ev_q[`RLH_EV_COLLIDE] & ~ev_q[`RLH_EV_WARN]
      |=> ~warn_q) else $error("warning not cleared");

   a_manual_quiet: assert property (~linkage_q & state_q == st_stopped
      |=> state_q == st_stopped) else $error("manual mode moved");

   a_mode_frozen: assert property (power_q ##1 power_q |-> $stable(linkage_q))
      else $error("mode changed while powered");

   a_power_on: assert property (lvl.pwr_on & ~lvl.shutdown |=> power_q)
      else $error("power-on ignored");

   a_shutdown: assert property (lvl.shutdown |=> ~power_q ##1 ~sw_alive_q ##1 ~sw_alive_out)
      else $error("shutdown ignored");

   a_teach_follow: assert property (power_q & lvl.teach |=> teach_q)
      else $error("teach not enabled");

   a_edge_once: assert property (rise.start |=> ~rise.start)
      else $error("start edge repeated");

   a_alive_out: assert property ($rose(sw_alive_q) |=> sw_alive_out)
      else $error("alive output late");

endmodule

/* core/rlh_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a 12-bit APB byte address
`ifndef RLH_MAP_SVH
`define RLH_MAP_SVH

// register byte offsets
`define RLH_OFF_STATUS 12'h000
`define RLH_OFF_EVENT  12'h004
`define RLH_OFF_CTRL   12'h008

// status register field positions
`define RLH_ST_RUNNING  0
`define RLH_ST_STOPPED  1
`define RLH_ST_PAUSED   2
`define RLH_ST_AT_HOME  3
`define RLH_ST_SW_ALIVE 4
`define RLH_ST_POWERED  5
`define RLH_ST_LINKAGE  6
`define RLH_ST_WARN     7
`define RLH_ST_TEACH    8
`define RLH_ST_GUARD    9
`define RLH_ST_HOMING   10
`define RLH_ST_W        11

// event register field positions, write one to pulse
`define RLH_EV_SW_READY 0
`define RLH_EV_SW_EXIT  1
`define RLH_EV_COLLIDE  2
`define RLH_EV_HOME     3
`define RLH_EV_PRG_DONE 4
`define RLH_EV_WARN     5
`define RLH_EV_W        6

// control register
`define RLH_CTRL_CMD_EN 0
`define RLH_CTRL_RESET  1'h1

// reset value of the link status outputs, stopped only
`define RLH_STATUS_RESET 5'h08

// settle time after software start
`define RLH_CLK_HZ       10000000
`define RLH_GUARD_TIME_S 10
`define RLH_GUARD_CYCLES (`RLH_GUARD_TIME_S * `RLH_CLK_HZ)
`define RLH_GUARD_W      27

`endif

/* core/rlh_pkg.sv */
// types shared by the linkage handshake block
// assumes nothing beyond a SystemVerilog compiler
package rlh_pkg;

   // command pins in one group, msb first
   typedef struct packed {
      logic mode_link;
      logic teach;
      logic msg_clr;
      logic shutdown;
      logic pwr_on;
      logic home;
      logic pause;
      logic stop;
      logic start;
   } rlh_pins_type;

   // link status outputs
   typedef struct packed {
      logic running;
      logic stopped;
      logic paused;
      logic at_home;
      logic sw_alive;
   } rlh_status_type;

   // program sequencer states
   typedef enum logic [1:0] {
      st_stopped,
      st_running,
      st_paused,
      st_homing
   } rlh_state_type;

endpackage

/* verification/rlh_ctrl_model.sv */
// external controller model that drives the linkage command pins
// assumes rlh_pkg is compiled first and clk runs freely from time zero
`timescale 1ns/10ps
module rlh_ctrl_model #(
   parameter int GUARD = 20
) (
   input  wire logic          clk,
   input  wire logic          sw_alive,
   output rlh_pkg::rlh_pins_type pins
);
   import rlh_pkg::*;

   // all pins idle low, selector at manual, until the bench asks
   initial pins = '0;

   // momentary switch: high for hi cycles, then low two, one edge per press
   task automatic press(input int i, input int hi);
      pins[i] <= 1'b1;
      repeat (hi) @(posedge clk);
      pins[i] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // level pins stay put; go-home is kept up for the whole move
   task automatic hold(input int i, input logic v);
      pins[i] <= v;
      @(posedge clk);
   endtask

   // no command until the settle time after software-alive has run out
   task automatic settle();
      int n;
      n = 0;
      while (sw_alive !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      repeat (GUARD) @(posedge clk);
   endtask
endmodule

/* verification/tb_robot_linkage_io_handshake.sv */
// self-checking bench: APB status reads against expectations queued by the driver
// assumes rlh_pkg, rlh_link_io and rlh_ctrl_model are compiled before it
`timescale 1ns/10ps
`include "rlh_map.svh"
module tb_robot_linkage_io_handshake;
   import rlh_pkg::*;
   localparam int GUARD = 20;
   localparam int P_GO = 0, P_STOP = 1, P_PAUSE = 2, P_HOME = 3, P_ON = 4;
   localparam int P_OFF = 5, P_CLR = 6, P_TEACH = 7, P_MODE = 8;
   localparam logic [32:0] M_ALL = 33'h1FFFFFFFF;
   localparam logic [32:0] M_ST  = 33'h005FF; // guard bit is checked on its own

   logic         clk, sys_rst, psel, penable, pwrite, pready, pslverr, sw_alive;
   logic         running, stopped, paused, at_home, power_en, teach_en, home_drive;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata;
   rlh_pins_type pins;
   logic [32:0]  exp_q[$], msk_q[$], e, m, pv;
   int           n_errors = 0, samples_checked = 0, n, k;

   rlh_link_io #(.GUARD_CYCLES(32'd20)) u_rlh_link_io (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .start_cmd_in(pins.start), .stop_cmd_in(pins.stop), .pause_toggle_in(pins.pause),
      .go_home_in(pins.home), .remote_power_on_in(pins.pwr_on),
      .remote_shutdown_in(pins.shutdown), .msg_clear_in(pins.msg_clr),
      .drag_teach_enable_in(pins.teach), .mode_link_sel_in(pins.mode_link),
      .running_out(running), .stopped_out(stopped), .paused_out(paused), .at_home_out(at_home),
      .sw_alive_out(sw_alive), .power_en_out(power_en), .drag_teach_out(teach_en),
      .home_drive_out(home_drive));

   rlh_ctrl_model #(.GUARD(GUARD)) u_rlh_ctrl_model (.clk(clk), .sw_alive(sw_alive), .pins(pins));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t read %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // one APB transfer, request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] ex, input logic [32:0] mk);
      if (!w) begin
         exp_q.push_back(ex);
         msk_q.push_back(mk);
      end
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so the next call never re-drives psel in this time step
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] ex, input logic [32:0] mk);
      apb(1'b0, a, 32'h0, ex, mk);
   endtask
   task automatic st(input logic [32:0] ex);
      rd(`RLH_OFF_STATUS, ex, M_ST);
   endtask
   task automatic ev(input logic [5:0] b);
      apb(1'b1, `RLH_OFF_EVENT, {26'h0, b}, 33'h0, 33'h0);
      repeat (3) @(posedge clk);
   endtask
   // press with a random width, then let sync, state and outputs settle
   task automatic cmd(input int i);
      u_rlh_ctrl_model.press(i, 1 + $urandom % 3);
      repeat (3) @(posedge clk);
   endtask

   // read results pop the oldest note; read data is only valid with pready
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         check({pslverr, prdata} & m, e);
         // status reads also hold the output pins to the same expectation
         if (paddr == `RLH_OFF_STATUS) begin
            pv = {22'h0, home_drive, 1'b0, teach_en, 2'h0, power_en, sw_alive, at_home, paused, stopped, running};
            check(pv & m & 33'h53F, e & 33'h53F);
         end
      end
   end

   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      close_out();
   end

   // main sequence
   initial begin
      void'($urandom(2193));
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      st(33'h002);
      rd(`RLH_OFF_CTRL, 33'h001, M_ALL);
      rd(12'h00C, 33'h100000000, M_ALL);
      apb(1'b1, `RLH_OFF_STATUS, 32'hFFFFFFFF, 33'h0, 33'h0);
      rd(`RLH_OFF_EVENT, 33'h000, M_ALL);
      st(33'h002);
      // manual mode power-up, selector low
      u_rlh_ctrl_model.hold(P_ON, 1'b1);
      repeat (5) @(posedge clk);
      ev(6'h01);
      st(33'h032);
      rd(`RLH_OFF_STATUS, 33'h000, 33'h200);
      u_rlh_ctrl_model.settle();
      rd(`RLH_OFF_STATUS, 33'h200, 33'h200);
      cmd(P_GO);
      st(33'h032);
      u_rlh_ctrl_model.hold(P_MODE, 1'b1);
      cmd(P_GO);
      st(33'h032);
      // power cycle latches linkage mode
      u_rlh_ctrl_model.hold(P_OFF, 1'b1);
      repeat (5) @(posedge clk);
      rd(`RLH_OFF_STATUS, 33'h000, 33'h020);
      u_rlh_ctrl_model.hold(P_OFF, 1'b0);
      repeat (5) @(posedge clk);
      ev(6'h01);
      u_rlh_ctrl_model.settle();
      st(33'h072);
      // homing moves only while held, at-home on arrival
      u_rlh_ctrl_model.hold(P_HOME, 1'b1);
      repeat (6) @(posedge clk);
      st(33'h472);
      u_rlh_ctrl_model.hold(P_HOME, 1'b0);
      repeat (6) @(posedge clk);
      st(33'h072);
      u_rlh_ctrl_model.hold(P_HOME, 1'b1);
      repeat (6) @(posedge clk);
      ev(6'h08);
      rd(`RLH_OFF_STATUS, 33'h07A, 33'h1FF);
      u_rlh_ctrl_model.hold(P_HOME, 1'b0);
      repeat (4) @(posedge clk);
      cmd(P_GO);
      st(33'h071);
      cmd(P_PAUSE);
      st(33'h074);
      cmd(P_PAUSE);
      st(33'h071);
      // collision, resume refused until the warning is cleared
      ev(6'h04);
      st(33'h0F4);
      cmd(P_PAUSE);
      st(33'h0F4);
      cmd(P_CLR);
      st(33'h074);
      cmd(P_PAUSE);
      st(33'h071);
      // random count of pause presses, each one toggles once
      n = 1 + $urandom % 4;
      for (k = 0; k < n; k++) cmd(P_PAUSE);
      st(n[0] ? 33'h074 : 33'h071);
      if (n[0]) cmd(P_PAUSE);
      cmd(P_STOP);
      st(33'h072);
      // commands gated off
      apb(1'b1, `RLH_OFF_CTRL, 32'h0, 33'h0, 33'h0);
      rd(`RLH_OFF_CTRL, 33'h000, M_ALL);
      cmd(P_GO);
      st(33'h072);
      apb(1'b1, `RLH_OFF_CTRL, 32'h1, 33'h0, 33'h0);
      // random start and stop presses
      for (k = 0; k < 6; k++) begin
         n = $urandom % 2;
         cmd(n[0] ? P_GO : P_STOP);
         st(n[0] ? 33'h071 : 33'h072);
      end
      cmd(P_STOP);
      u_rlh_ctrl_model.hold(P_TEACH, 1'b1);
      repeat (6) @(posedge clk);
      st(33'h172);
      u_rlh_ctrl_model.hold(P_TEACH, 1'b0);
      repeat (6) @(posedge clk);
      st(33'h072);
      ev(6'h02);
      rd(`RLH_OFF_STATUS, 33'h000, 33'h010);
      repeat (2) @(posedge clk);
      close_out();
   end
endmodule
